/* src/spio_defines.svh */
// constants for the shared pin port with change notice
`ifndef SPIO_DEFINES_SVH
`define SPIO_DEFINES_SVH

`define SPIO_WIDTH_DEFAULT 16
`define SPIO_WIDTH_MAX     32
`define SPIO_CN_MAX        81
`define SPIO_DIR_RESET     1'b1
`define SPIO_LAT_RESET     1'b0
`define SPIO_ODC_RESET     1'b0
`define SPIO_SEL_DIR       2'h0
`define SPIO_SEL_LAT       2'h1
`define SPIO_SEL_PIN       2'h2
`define SPIO_SEL_ODC       2'h3
`define SPIO_PRIME_CYCLES  2'h3

`endif

/* src/spio_pkg.sv */
// types shared by the port logic
`include "spio_defines.svh"

package spio_pkg;

   typedef enum logic [1:0] {
      SPIO_REG_DIR = `SPIO_SEL_DIR,
      SPIO_REG_LAT = `SPIO_SEL_LAT,
      SPIO_REG_PIN = `SPIO_SEL_PIN,
      SPIO_REG_ODC = `SPIO_SEL_ODC
   } spio_reg_type;

   typedef struct packed {
      logic         valid;
      spio_reg_type sel;
   } spio_wr_type;

endpackage : spio_pkg

/* src/spio_sync.sv */
// pin synchroniser with stored previous sample and change flags
`timescale 1ns/1ps
`include "spio_defines.svh"

module spio_sync
   import spio_pkg::*;
#(
   parameter int WIDTH = `SPIO_WIDTH_DEFAULT
)
(
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out,
   output logic      [WIDTH-1:0] prev_out,
   output logic      [WIDTH-1:0] change
);

   logic [WIDTH-1:0] meta;
   logic [1:0]       prime;

   if (WIDTH < 1 || WIDTH > `SPIO_WIDTH_MAX)
   begin : g_width_check
      $error("spio_sync: WIDTH out of range");
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         meta     <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         prev_out <= '0;
      else
         prev_out <= sync_out;
   end

   // no changes until the stored sample is a real pin sample, not the reset zero
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         prime <= '0;
      else if (prime != `SPIO_PRIME_CYCLES)
         prime <= prime + 2'h1;
   end

   assign change = (prime == `SPIO_PRIME_CYCLES) ? (sync_out ^ prev_out) : '0;

endmodule : spio_sync

/* src/spio_port.sv */
// shared pin port: direction, latch, open drain, pin mux and change notice
`timescale 1ns/1ps
`include "spio_defines.svh"

module spio_port
   import spio_pkg::*;
#(
   parameter int               WIDTH     = `SPIO_WIDTH_DEFAULT,
   parameter logic [WIDTH-1:0] IMPL_MASK = '1
)
(
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire spio_wr_type      reg_wr,
   input  wire logic [WIDTH-1:0] reg_wdata,
   output logic      [WIDTH-1:0] direction_reg,
   output logic      [WIDTH-1:0] output_latch_reg,
   output logic      [WIDTH-1:0] open_drain_select,
   output logic      [WIDTH-1:0] pin_level,
   input  wire logic [WIDTH-1:0] analog_pin_config,
   input  wire logic [WIDTH-1:0] change_irq_enable,
   input  wire logic [WIDTH-1:0] weak_pullup_enable,
   input  wire logic [WIDTH-1:0] weak_pulldown_enable,
   input  wire logic             change_irq_clear,
   output logic                  change_irq,
   output logic                  change_wake,
   input  wire logic [WIDTH-1:0] periph_enable,
   input  wire logic [WIDTH-1:0] periph_drive,
   input  wire logic [WIDTH-1:0] periph_out,
   output logic      [WIDTH-1:0] periph_in,
   input  wire logic [WIDTH-1:0] remap_out_enable,
   input  wire logic [WIDTH-1:0] remap_out,
   output logic      [WIDTH-1:0] remap_in,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe,
   output logic      [WIDTH-1:0] pullup_on,
   output logic      [WIDTH-1:0] pulldown_on
);

   logic [WIDTH-1:0] pin_sync;
   logic [WIDTH-1:0] pin_prev;
   logic [WIDTH-1:0] pin_change;
   logic [WIDTH-1:0] remap_owns;
   logic [WIDTH-1:0] periph_owns;
   logic [WIDTH-1:0] port_owns;
   logic [WIDTH-1:0] port_drive;
   logic [WIDTH-1:0] src_val;
   logic [WIDTH-1:0] src_drive;
   logic [WIDTH-1:0] cn_hit;

   if (WIDTH < 1 || WIDTH > `SPIO_WIDTH_MAX)
   begin : g_width_check
      $error("spio_port: WIDTH out of range");
   end

   function automatic logic [WIDTH-1:0] impl_only(input logic [WIDTH-1:0] v);
      impl_only = v & IMPL_MASK;
   endfunction : impl_only

   function automatic logic wr_hit(input spio_wr_type w, input spio_reg_type s);
      wr_hit = w.valid && (w.sel == s);
   endfunction : wr_hit

   spio_sync #(
      .WIDTH    (WIDTH)
   ) u_sync (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .async_in (pin_in),
      .sync_out (pin_sync),
      .prev_out (pin_prev),
      .change   (pin_change)
   );

   // control registers
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         direction_reg <= impl_only({WIDTH{`SPIO_DIR_RESET}});
      else if (wr_hit(reg_wr, SPIO_REG_DIR))
         direction_reg <= impl_only(reg_wdata);
   end

   // writes to the pin level land in the latch as well
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         output_latch_reg <= {WIDTH{`SPIO_LAT_RESET}};
      else if (wr_hit(reg_wr, SPIO_REG_LAT) || wr_hit(reg_wr, SPIO_REG_PIN))
         output_latch_reg <= impl_only(reg_wdata);
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         open_drain_select <= {WIDTH{`SPIO_ODC_RESET}};
      else if (wr_hit(reg_wr, SPIO_REG_ODC))
         open_drain_select <= impl_only(reg_wdata);
   end

   // pin read path, three cycles behind the pin (two synchroniser stages and this register), which software covers by waiting
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         pin_level <= '0;
      else
         pin_level <= impl_only(pin_sync & ~analog_pin_config);
   end

   // output ownership: remap, then fixed peripheral, then port
   always_comb
   begin
      remap_owns  = impl_only(remap_out_enable);
      periph_owns = impl_only(periph_enable & periph_drive) & ~remap_owns;
      port_owns   = IMPL_MASK & ~remap_owns & ~periph_owns;
      port_drive  = port_owns & ~direction_reg;
      src_val     = (remap_owns & remap_out) | (periph_owns & periph_out)
                  | (port_owns & output_latch_reg);
      src_drive   = remap_owns | periph_owns | port_drive;
   end

   // open drain: a high is a release, so the pin never sees a driven one
   always_comb
   begin
      pin_out = src_val & ~open_drain_select;
      pin_oe  = src_drive & ~(open_drain_select & src_val);
   end

   // fixed peripheral inputs are blind while the port itself drives the pin; remap inputs are blind only on analog pins
   always_comb
   begin
      periph_in = pin_sync & ~port_drive & IMPL_MASK;
      remap_in  = pin_sync & ~analog_pin_config & IMPL_MASK;
   end

   // analog pins keep their weak devices, software turns them off
   always_comb
   begin
      pullup_on   = impl_only(weak_pullup_enable);
      pulldown_on = impl_only(weak_pulldown_enable);
   end

   // change notice
   assign cn_hit = impl_only(pin_change & change_irq_enable);

   // set beats clear so an edge in the clearing cycle is kept
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         change_irq <= 1'b0;
      else if (|cn_hit)
         change_irq <= 1'b1;
      else if (change_irq_clear)
         change_irq <= 1'b0;
   end

   // raw pins against the last stored sample: works with the clock stopped
   assign change_wake = |impl_only((pin_in ^ pin_prev) & change_irq_enable);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   chk_periph_owns_pin: assert property (
      ((pin_oe | ~(periph_enable & periph_drive & ~remap_out_enable & IMPL_MASK
                   & ~open_drain_select)) == '1)
      && (((pin_out ^ periph_out) & periph_enable & periph_drive & ~remap_out_enable
           & IMPL_MASK & ~open_drain_select) == '0))
      else $error("enabled driving peripheral does not own pin");

   chk_idle_periph_port: assert property (
      (!periph_drive[0] && !remap_out_enable[0] && IMPL_MASK[0])
      |-> (pin_oe[0] == (!direction_reg[0]
           && !(open_drain_select[0] && output_latch_reg[0]))))
      else $error("idle peripheral pin not under port control");

   chk_no_loop_through: assert property (
      (periph_in & port_drive) == '0)
      else $error("port output looped into peripheral input");

   chk_reset_all_inputs: assert property (
      $rose(reset_n) |-> direction_reg == IMPL_MASK)
      else $error("pins not inputs after reset");

   chk_pin_write_latch: assert property (
      (reg_wr.valid && reg_wr.sel == SPIO_REG_PIN)
      |=> output_latch_reg == ($past(reg_wdata) & IMPL_MASK))
      else $error("pin level write did not reach latch");

   chk_unimpl_zero: assert property (
      ((direction_reg | output_latch_reg | pin_level | pin_oe) & ~IMPL_MASK) == '0)
      else $error("unimplemented bit not zero");

   chk_open_drain_high: assert property (
      (pin_oe & open_drain_select & pin_out) == '0)
      else $error("open drain pin driven high");

   chk_analog_reads_zero: assert property (
      ##1 (pin_level & $past(analog_pin_config)) == '0)
      else $error("analog pin read nonzero");

   chk_irq_cause: assert property (
      $rose(change_irq) |-> $past(cn_hit) != '0)
      else $error("request raised without enabled change");

   chk_irq_sticky: assert property (
      (change_irq && !change_irq_clear) |=> change_irq)
      else $error("request dropped without clear");

   chk_set_beats_clear: assert property (
      (|cn_hit && change_irq_clear) |=> change_irq)
      else $error("change lost in clearing cycle");

   chk_change_from_sync: assert property (
      (|pin_change) |-> $past(pin_sync) != pin_sync)
      else $error("change without sample difference");

endmodule : spio_port

/* sim/spio_pad_model.sv */
// pad model: pin level from port drive, outside driver and weak devices
`timescale 1ns/1ps

module spio_pad_model
#(
   parameter int WIDTH = 16
)
(
   input  wire logic             ref_clk,
   input  wire logic [WIDTH-1:0] pin_out,
   input  wire logic [WIDTH-1:0] pin_oe,
   input  wire logic [WIDTH-1:0] pullup_on,
   input  wire logic [WIDTH-1:0] pulldown_on,
   input  wire logic [WIDTH-1:0] ext_oe,
   input  wire logic [WIDTH-1:0] ext_val,
   output logic      [WIDTH-1:0] pin_in
);
   // an undriven pad keeps changing, so no settled guess can pass
   logic [WIDTH-1:0] float_val = '0;

   always_ff @(posedge ref_clk)
   begin
      float_val <= ~float_val;
   end

   always_comb
   begin
      for (int i = 0; i < WIDTH; i++)
      begin
         if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (ext_oe[i])
            pin_in[i] = ext_val[i];
         else if (pullup_on[i])
            pin_in[i] = 1'b1;
         else if (pulldown_on[i])
            pin_in[i] = 1'b0;
         else
            pin_in[i] = float_val[i];
      end
   end
endmodule : spio_pad_model

/* sim/tb_spio_port.sv */
// self-checking bench for the shared pin port
`timescale 1ns/1ps

`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module tb_spio_port
   import spio_pkg::*;
();
   localparam logic [15:0] IMPL = 16'h7FFF;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   spio_wr_type reg_wr  = '0;
   logic [15:0] wdata = '0, analog = '0, cn_en = '0, pu_en = '0, pd_en = '0;
   logic [15:0] p_en = '0, p_drv = '0, p_out = '0, r_oe = '0, r_out = '0;
   logic [15:0] ext_oe = '0, ext_val = '0;
   logic [15:0] dir_q, lat_q, odc_q, lvl, p_in, r_in, pin_in, pin_out, pin_oe, pu_on, pd_on;
   logic        cn_clr = 1'b0;
   logic        irq, wake;
   int          n_errors = 0;
   int          checks = 0;
   int          k;

   always #2.5 ref_clk = ~ref_clk;

   spio_port #(.WIDTH(16), .IMPL_MASK(IMPL)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .reg_wr(reg_wr), .reg_wdata(wdata), .direction_reg(dir_q), .output_latch_reg(lat_q),
      .open_drain_select(odc_q), .pin_level(lvl), .analog_pin_config(analog),
      .change_irq_enable(cn_en), .weak_pullup_enable(pu_en), .weak_pulldown_enable(pd_en),
      .change_irq_clear(cn_clr), .change_irq(irq), .change_wake(wake),
      .periph_enable(p_en), .periph_drive(p_drv), .periph_out(p_out), .periph_in(p_in),
      .remap_out_enable(r_oe), .remap_out(r_out), .remap_in(r_in), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pu_on), .pulldown_on(pd_on));

   spio_pad_model #(.WIDTH(16)) pads (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_on(pu_on), .pulldown_on(pd_on), .ext_oe(ext_oe), .ext_val(ext_val),
      .pin_in(pin_in));

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   task automatic wr(input spio_reg_type sel, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= '{valid: 1'b1, sel: sel};
      wdata  <= d;
      @(posedge ref_clk);
      reg_wr <= '0;
      cyc(1);
   endtask : wr

   task automatic final_report;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   initial
   begin
      cyc(3);
      @(posedge ref_clk);
      reset_n <= 1'b1;
      cyc(1);
      `CHK(dir_q, IMPL)
      `CHK(lat_q | odc_q, 16'h0000)
      `CHK(pin_oe, 16'h0000)
      wr(SPIO_REG_DIR, 16'hFF00);
      `CHK(dir_q, 16'h7F00)
      wr(SPIO_REG_LAT, 16'hFFA5);
      `CHK(lat_q, 16'h7FA5)
      `CHK(pin_oe, 16'h00FF)
      `CHK(pin_out & 16'h00FF, 16'h00A5)
      @(posedge ref_clk);
      ext_oe  <= 16'hFF00;
      ext_val <= 16'hC300;
      wr(SPIO_REG_PIN, 16'h1234);
      `CHK(lat_q, 16'h1234)
      cyc(3);
      `CHK(lvl, 16'h4334)
      @(posedge ref_clk);
      analog <= 16'h0300;
      cyc(2);
      `CHK(lvl, 16'h4034)
      `CHK(r_in & IMPL, 16'h4034)
      wr(SPIO_REG_ODC, 16'h000F);
      `CHK(odc_q, 16'h000F)
      `CHK(pin_oe, 16'h00FB)
      @(posedge ref_clk);
      p_en  <= 16'h0030;
      p_drv <= 16'h0010;
      cyc(4);
      `CHK({pin_oe[5:4], pin_out[5:4]}, 4'hE)
      `CHK(lvl[4], 1'b0)
      `CHK(p_in & 16'h00EB, 16'h0000)
      @(posedge ref_clk);
      r_oe  <= 16'h0050;
      r_out <= 16'h0050;
      cyc(1);
      `CHK({pin_oe[6], pin_oe[4], pin_out[6], pin_out[4]}, 4'hF)
      @(posedge ref_clk);
      analog <= '0;
      cn_en  <= 16'h0100;
      cn_clr <= 1'b1;
      @(posedge ref_clk);
      cn_clr  <= 1'b0;
      ext_val <= 16'hC100;
      cyc(6);
      `CHK({irq, wake}, 2'b00)
      @(posedge ref_clk);
      ext_val <= 16'hC000;
      #1;
      `CHK(wake, 1'b1)
      k = 0;
      while (irq !== 1'b1 && k < 8)
      begin
         cyc(1);
         k++;
      end
      if (k == 8)
      begin
         n_errors++;
      end
      `CHK(k, 3)
      cyc(5);
      `CHK(irq, 1'b1)
      @(posedge ref_clk);
      cn_clr <= 1'b1;
      @(posedge ref_clk);
      cn_clr <= 1'b0;
      cyc(1);
      `CHK(irq, 1'b0)
      @(posedge ref_clk);
      ext_val <= 16'hC100;
      repeat (2) @(posedge ref_clk);
      cn_clr <= 1'b1;
      @(posedge ref_clk);
      cn_clr <= 1'b0;
      cyc(1);
      `CHK(irq, 1'b1)
      @(posedge ref_clk);
      pu_en <= 16'hA000;
      pd_en <= 16'h0504;
      cyc(1);
      `CHK(pu_on, 16'h2000)
      `CHK(pd_on, 16'h0504)
      cyc(4);
      `CHK(lvl[2], 1'b0)
      cyc(1);
      `CHK(lvl[2], 1'b0)
      final_report();
   end
endmodule : tb_spio_port
